/* File: lpddr_map.svh */
// constants for the lpddr command, mode and burst logic
// Summary of operation
// - address and control are taken only at the rising clock edge.
// - data moves on both halves of each clock, rise and fall beats.
// - one 32-bit core transfer per cycle, split into two 16-bit beats.
// - clock enable high runs the device; low stops it.
// - enable low: idle banks give power-down or self refresh, open row active.
// - enable sampled at rising edges, self refresh exit included.
// - in power-down and self refresh all inputs but enable are ignored.
// - chip select low enables decoding; high masks every command.
// - command decoded from select, row, column and write strobes together.
// - write byte dropped when its mask is high with it, per beat.
// - bank select picks the bank of activate, read, write, precharge.
// - address carries row, column plus auto close bit, or mode opcode.
// - each bank has 8192 rows of 512 sixteen-bit columns.
// - read strobes edge-aligned to data; write strobes from controller.
// - read or write only to a bank opened by activate.
// - read latency 2 or 3, burst 2, 4, 8, 16, sequential or interleaved.
// - reset loads burst 2, latency 3; both registers must still be loaded.
// - read and write only after initialization completes; clock stop and other commands any time.
// - base mode: burst length bits 0-2, type bit 3, latency bits 4-6.
// - burst wraps inside a column block the size of the burst.
`ifndef LPDDR_MAP_SVH
`define LPDDR_MAP_SVH
// command codes {select, row, column, write}, all active low
`define CMD_MODE_LOAD    4'h0
`define CMD_REFRESH      4'h1
`define CMD_PRECHARGE    4'h2
`define CMD_ACTIVATE     4'h3
`define CMD_WRITE        4'h4
`define CMD_READ         4'h5
`define CMD_BURST_STOP   4'h6
`define CMD_NOP          4'h7
`define MR_BASE_BANK     2'h0
`define MR_EXT_BANK      2'h2
`define MR_BL_LSB        0
`define MR_BL_MSB        2
`define MR_TYPE_BIT      3
`define MR_CL_LSB        4
`define MR_CL_MSB        6
`define CL_TWO           3'h2
`define CL_THREE         3'h3
`define BL_CODE_2        3'h1
`define BL_CODE_4        3'h2
`define BL_CODE_8        3'h3
`define BL_CODE_16       3'h4
`define AUTO_CLOSE_BIT   10
`define INIT_REFRESHES   2'h2
`define RESET_BL_CODE    3'h1
`define RESET_CL_CODE    3'h3
`define ROW_BITS         13
`define COL_BITS         9
`define MEM_WORDS        (1 << 24)
`endif

/* File: lpddr_pkg.sv */
// types shared by the lpddr core
package lpddr_pkg;
   typedef enum logic [1:0] {
      PWR_ON       = 2'b00,
      PWR_PRE_DOWN = 2'b01,
      PWR_ACT_DOWN = 2'b10,
      PWR_SELF_REF = 2'b11
   } pwr_t;
   typedef enum logic [1:0] {
      BST_IDLE = 2'b00,
      BST_RD   = 2'b01,
      BST_WR   = 2'b10
   } burst_t;
endpackage : lpddr_pkg

/* File: lpddr_skid.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module lpddr_skid #(
   parameter int W = 32
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   logic [W-1:0] d0_r;
   logic [W-1:0] d1_r;
   logic [1:0]   cnt_r;
   wire          pop  = out_valid && out_ready;
   wire          push = in_valid && in_ready;

   assign in_ready  = cnt_r != 2'h2;
   assign out_valid = cnt_r != 2'h0;
   assign out_data  = d0_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop))) begin
         d0_r <= in_data;
      end else if (pop) begin
         d0_r <= d1_r;
      end
      if (push && cnt_r == 2'h1 && !pop) begin
         d1_r <= in_data;
      end
   end
endmodule : lpddr_skid

/* File: lpddr_core.sv */
// lpddr command decoder, banks, bursts, power states and storage
`timescale 1ns/1ps
`include "lpddr_map.svh"
module lpddr_core (
   input  wire logic        CLOCK,
   input  wire logic        SRST,
   input  wire logic        CKE,
   input  wire logic        CS_N,
   input  wire logic        RAS_N,
   input  wire logic        CAS_N,
   input  wire logic        WE_N,
   input  wire logic [1:0]  BANK_SELECT,
   input  wire logic [12:0] ADDR,
   input  wire logic [15:0] DATA_LINES_IN_RISE,
   input  wire logic [15:0] DATA_LINES_IN_FALL,
   input  wire logic [1:0]  WRITE_BYTE_MASK_RISE,
   input  wire logic [1:0]  WRITE_BYTE_MASK_FALL,
   input  wire logic        LOW_BYTE_STROBE_IN,
   input  wire logic        HIGH_BYTE_STROBE_IN,
   output logic [15:0]      DATA_LINES_OUT_RISE,
   output logic [15:0]      DATA_LINES_OUT_FALL,
   output logic             DATA_LINES_OE,
   output logic             LOW_BYTE_STROBE_OUT,
   output logic             HIGH_BYTE_STROBE_OUT,
   output logic             STROBE_OE,
   input  wire logic        RD_READY,
   output logic             INIT_DONE,
   output logic [3:0]       BANK_OPEN,
   output logic [1:0]       POWER_STATE,
   output logic             CMD_ERROR
);
   lpddr_pkg::pwr_t   pwr_r;
   lpddr_pkg::pwr_t   pwr_nxt;
   lpddr_pkg::burst_t burst_r;
   logic [3:0]        bank_open_r;
   logic [12:0]       row_r [0:3];
   logic [2:0]        bl_code_r;
   logic              il_r;
   logic [2:0]        cl_code_r;
   logic              pre_all_r;
   logic [1:0]        ref_cnt_r;
   logic              mr_base_r;
   logic              mr_ext_r;
   logic              init_done_r;
   logic [1:0]        bank_r;
   logic [8:0]        col_r;
   logic [4:0]        idx_r;
   logic              ap_r;
   logic [1:0]        wait_r;
   logic              cmd_err_r;
   logic [15:0]       mem [0:`MEM_WORDS-1];

   // burst length from its mode code
   function automatic logic [4:0] burst_len(input logic [2:0] code);
      case (code)
         `BL_CODE_4:  burst_len = 5'h04;
         `BL_CODE_8:  burst_len = 5'h08;
         `BL_CODE_16: burst_len = 5'h10;
         default:     burst_len = 5'h02;
      endcase
   endfunction : burst_len

   // column of beat idx, wrapping in a block of bl columns
   function automatic logic [8:0] burst_col(input logic [8:0] start,
                                            input logic [4:0] idx,
                                            input logic [4:0] bl,
                                            input logic       il);
      logic [8:0] m;
      logic [8:0] off;
      m   = {4'h0, bl - 5'h01};
      off = il ? (start ^ {4'h0, idx}) : (start + {4'h0, idx});
      burst_col = (start & ~m) | (off & m);
   endfunction : burst_col

   // command decode, all pins taken at the same edge
   wire [3:0]  cmd     = {CS_N, RAS_N, CAS_N, WE_N};
   wire        awake   = pwr_r == lpddr_pkg::PWR_ON && CKE;
   wire        sel     = awake && !CS_N;
   wire        busy    = burst_r != lpddr_pkg::BST_IDLE;
   wire        idle_all = bank_open_r == 4'h0;
   wire        is_act  = sel && cmd == `CMD_ACTIVATE;
   wire        is_rd   = sel && cmd == `CMD_READ;
   wire        is_wr   = sel && cmd == `CMD_WRITE;
   wire        is_pre  = sel && cmd == `CMD_PRECHARGE;
   wire        is_ref  = sel && cmd == `CMD_REFRESH;
   wire        is_mrs  = sel && cmd == `CMD_MODE_LOAD;
   wire        is_idle = !sel || cmd == `CMD_NOP || cmd == `CMD_BURST_STOP;
   wire        bank_on = bank_open_r[BANK_SELECT];
   wire        act_go  = is_act && !bank_on;
   wire        rd_go   = is_rd && bank_on && !busy && init_done_r;
   wire        wr_go   = is_wr && bank_on && !busy && init_done_r;
   wire        pre_go  = is_pre && !busy;
   wire        pre_all = ADDR[`AUTO_CLOSE_BIT];
   wire        ref_go  = is_ref && idle_all && !busy;
   wire        mrs_go  = is_mrs && idle_all && !busy;
   wire        cmd_ok  = is_idle || act_go || rd_go || wr_go || pre_go || ref_go || mrs_go;
   wire [3:0]  bank_bit = 4'h1 << BANK_SELECT;

   // burst addressing, two columns per core transfer
   wire [4:0]  bl      = burst_len(bl_code_r);
   wire [4:0]  idx_nxt = idx_r + 5'h02;
   wire        last    = idx_nxt == bl;
   wire [8:0]  col0    = burst_col(col_r, idx_r, bl, il_r);
   wire [8:0]  col1    = burst_col(col_r, idx_r + 5'h01, bl, il_r);
   wire [23:0] addr0   = {bank_r, row_r[bank_r], col0};
   wire [23:0] addr1   = {bank_r, row_r[bank_r], col1};
   wire [31:0] rd_pair = {mem[addr1], mem[addr0]};
   wire        cl3     = cl_code_r == `CL_THREE;
   wire        buf_rdy;
   wire        buf_vld;
   wire [31:0] buf_data;
   wire        push    = burst_r == lpddr_pkg::BST_RD && awake && wait_r == 2'h0 && buf_rdy;
   wire        wr_beat = burst_r == lpddr_pkg::BST_WR && awake
                         && (LOW_BYTE_STROBE_IN || HIGH_BYTE_STROBE_IN);
   wire        step    = push || wr_beat;

   // byte enables per half beat, mask high drops the byte
   wire        we_r_lo = wr_beat && LOW_BYTE_STROBE_IN && !WRITE_BYTE_MASK_RISE[0];
   wire        we_r_hi = wr_beat && HIGH_BYTE_STROBE_IN && !WRITE_BYTE_MASK_RISE[1];
   wire        we_f_lo = wr_beat && LOW_BYTE_STROBE_IN && !WRITE_BYTE_MASK_FALL[0];
   wire        we_f_hi = wr_beat && HIGH_BYTE_STROBE_IN && !WRITE_BYTE_MASK_FALL[1];

   // power state selection
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         lpddr_pkg::PWR_ON: begin
            if (!CKE) begin
               if (!idle_all) begin
                  pwr_nxt = lpddr_pkg::PWR_ACT_DOWN;
               end else if (!CS_N && cmd == `CMD_REFRESH && !busy) begin
                  pwr_nxt = lpddr_pkg::PWR_SELF_REF;
               end else begin
                  pwr_nxt = lpddr_pkg::PWR_PRE_DOWN;
               end
            end
         end
         lpddr_pkg::PWR_SELF_REF: begin
            if (CKE) begin
               pwr_nxt = lpddr_pkg::PWR_ON;
            end
         end
         default: begin
            if (CKE) begin
               pwr_nxt = lpddr_pkg::PWR_ON;
            end
         end
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         pwr_r <= lpddr_pkg::PWR_ON;
      end else begin
         pwr_r <= pwr_nxt;
      end
   end

   // bank rows, opened by activate, closed by precharge or auto close
   // an activate may meet the auto close of another bank in one edge
   wire [3:0]  pre_bits  = pre_all ? 4'hf : bank_bit;
   wire [3:0]  auto_bits = (step && last && ap_r) ? 4'h1 << bank_r : 4'h0;
   wire [3:0]  shut_bits = (pre_go ? pre_bits : 4'h0) | auto_bits;
   wire [3:0]  open_bits = act_go ? bank_bit : 4'h0;
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         bank_open_r <= 4'h0;
      end else begin
         bank_open_r <= (bank_open_r & ~shut_bits) | open_bits;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (act_go) begin
         row_r[BANK_SELECT] <= ADDR;
      end
   end

   // mode registers and initialization progress
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         bl_code_r <= `RESET_BL_CODE;
         il_r      <= 1'b0;
         cl_code_r <= `RESET_CL_CODE;
         mr_base_r <= 1'b0;
         mr_ext_r  <= 1'b0;
         pre_all_r <= 1'b0;
         ref_cnt_r <= 2'h0;
      end else begin
         if (mrs_go && BANK_SELECT == `MR_BASE_BANK) begin
            bl_code_r <= ADDR[`MR_BL_MSB:`MR_BL_LSB];
            il_r      <= ADDR[`MR_TYPE_BIT];
            cl_code_r <= ADDR[`MR_CL_MSB:`MR_CL_LSB];
            mr_base_r <= 1'b1;
         end
         if (mrs_go && BANK_SELECT == `MR_EXT_BANK) begin
            mr_ext_r <= 1'b1;
         end
         if (pre_go && pre_all) begin
            pre_all_r <= 1'b1;
         end
         if (ref_go && ref_cnt_r != `INIT_REFRESHES) begin
            ref_cnt_r <= ref_cnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         init_done_r <= 1'b0;
      end else begin
         init_done_r <= pre_all_r && ref_cnt_r == `INIT_REFRESHES
                        && mr_base_r && mr_ext_r;
      end
   end

   // burst sequencing
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         burst_r <= lpddr_pkg::BST_IDLE;
         bank_r  <= 2'h0;
         col_r   <= 9'h000;
         idx_r   <= 5'h00;
         ap_r    <= 1'b0;
         wait_r  <= 2'h0;
      end else if (rd_go || wr_go) begin
         burst_r <= rd_go ? lpddr_pkg::BST_RD : lpddr_pkg::BST_WR;
         bank_r  <= BANK_SELECT;
         col_r   <= ADDR[`COL_BITS-1:0];
         ap_r    <= ADDR[`AUTO_CLOSE_BIT];
         idx_r   <= 5'h00;
         wait_r  <= cl3 ? 2'h2 : 2'h1;
      end else if (burst_r == lpddr_pkg::BST_RD && awake && wait_r != 2'h0) begin
         wait_r <= wait_r - 2'h1;
      end else if (step) begin
         idx_r <= idx_nxt;
         if (last) begin
            burst_r <= lpddr_pkg::BST_IDLE;
         end
      end
   end

   // storage, rise beat to first column, fall beat to second
   always_ff @(posedge CLOCK) begin
      if (we_r_lo) begin
         mem[addr0][7:0] <= DATA_LINES_IN_RISE[7:0];
      end
      if (we_r_hi) begin
         mem[addr0][15:8] <= DATA_LINES_IN_RISE[15:8];
      end
      if (we_f_lo) begin
         mem[addr1][7:0] <= DATA_LINES_IN_FALL[7:0];
      end
      if (we_f_hi) begin
         mem[addr1][15:8] <= DATA_LINES_IN_FALL[15:8];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         cmd_err_r <= 1'b0;
      end else begin
         cmd_err_r <= awake && !cmd_ok;
      end
   end

   // read data buffer, pins stall it without losing a word
   lpddr_skid #(.W(32)) u_rd_buf (
      .clk       (CLOCK),
      .srst      (SRST),
      .in_valid  (push),
      .in_ready  (buf_rdy),
      .in_data   (rd_pair),
      .out_valid (buf_vld),
      .out_ready (RD_READY && awake),
      .out_data  (buf_data)
   );

   assign DATA_LINES_OUT_RISE  = buf_data[15:0];
   assign DATA_LINES_OUT_FALL  = buf_data[31:16];
   assign DATA_LINES_OE        = buf_vld && awake;
   assign LOW_BYTE_STROBE_OUT  = DATA_LINES_OE;
   assign HIGH_BYTE_STROBE_OUT = DATA_LINES_OE;
   assign STROBE_OE            = DATA_LINES_OE;
   assign INIT_DONE            = init_done_r;
   assign BANK_OPEN            = bank_open_r;
   assign POWER_STATE          = pwr_r;
   assign CMD_ERROR            = cmd_err_r;

   a_cs_masks: assert property (@(posedge CLOCK) disable iff (SRST)
      (CS_N && !busy) |=> (burst_r == lpddr_pkg::BST_IDLE && $stable(bank_open_r)))
      else $error("deselected command changed state");

   a_act_opens: assert property (@(posedge CLOCK) disable iff (SRST)
      act_go |=> bank_open_r[$past(BANK_SELECT)] && row_r[$past(BANK_SELECT)] == $past(ADDR))
      else $error("activate did not open the selected row");

   a_pdn_kind: assert property (@(posedge CLOCK) disable iff (SRST)
      (pwr_r == lpddr_pkg::PWR_ON && !CKE && !idle_all)
      |=> pwr_r == lpddr_pkg::PWR_ACT_DOWN)
      else $error("open row did not give active power-down");

   a_down_frozen: assert property (@(posedge CLOCK) disable iff (SRST)
      (pwr_r != lpddr_pkg::PWR_ON) |=> $stable(bank_open_r) && !CMD_ERROR)
      else $error("inputs acted on while powered down");

   a_sref_exit: assert property (@(posedge CLOCK) disable iff (SRST)
      (pwr_r == lpddr_pkg::PWR_SELF_REF && CKE) |=> pwr_r == lpddr_pkg::PWR_ON)
      else $error("self refresh exit missed");

   a_init_gate: assert property (@(posedge CLOCK) disable iff (SRST)
      (!init_done_r && is_rd) |=> burst_r == lpddr_pkg::BST_IDLE ##0 CMD_ERROR)
      else $error("read accepted before initialization");

   a_rd_latency: assert property (@(posedge CLOCK) disable iff (SRST)
      (rd_go && cl3 && CKE && $stable(CKE)) |=> !push ##1 !push)
      else $error("read data earlier than latency three");

   a_strobe_align: assert property (@(posedge CLOCK) disable iff (SRST)
      DATA_LINES_OE |-> LOW_BYTE_STROBE_OUT && HIGH_BYTE_STROBE_OUT && STROBE_OE
      && pwr_r == lpddr_pkg::PWR_ON)
      else $error("read strobe not aligned with data");

   a_mask_drop: assert property (@(posedge CLOCK) disable iff (SRST)
      (wr_beat && WRITE_BYTE_MASK_RISE[0])
      |=> mem[$past(addr0)][7:0] == $past(mem[addr0][7:0]))
      else $error("masked byte was written");

   a_wr_closed: assert property (@(posedge CLOCK) disable iff (SRST)
      (is_wr && !bank_on && !busy) |=> burst_r == lpddr_pkg::BST_IDLE && CMD_ERROR)
      else $error("write to a closed bank accepted");

   a_mode_fields: assert property (@(posedge CLOCK) disable iff (SRST)
      (mrs_go && BANK_SELECT == `MR_BASE_BANK)
      |=> bl_code_r == $past(ADDR[`MR_BL_MSB:`MR_BL_LSB]) && il_r == $past(ADDR[`MR_TYPE_BIT])
      && cl_code_r == $past(ADDR[`MR_CL_MSB:`MR_CL_LSB]))
      else $error("base mode fields not loaded");

   a_auto_close: assert property (@(posedge CLOCK) disable iff (SRST)
      (step && last && ap_r) |=> !bank_open_r[$past(bank_r)])
      else $error("auto close left the row open");

   a_desel_quiet: assert property (@(posedge CLOCK) disable iff (SRST)
      (awake && CS_N) |=> !CMD_ERROR)
      else $error("deselected command flagged an error");
endmodule : lpddr_core

/* File: lpddr_ctrl_model.sv */
// controller-side model: power-up idle, init sequence, commands and write beats
`timescale 1ns/1ps
`include "lpddr_map.svh"
module lpddr_ctrl_model #(
   parameter int POWER_UP_IDLE      = 2000,
   parameter int PRECHARGE_WAIT     = 2,
   parameter int REFRESH_CYCLE_WAIT = 4,
   parameter int MODE_LOAD_WAIT     = 2
) (
   input  wire logic   clock,
   output logic        cke,
   output logic [3:0]  cmd,
   output logic [1:0]  bank_select,
   output logic [12:0] addr,
   output logic [15:0] d_rise,
   output logic [15:0] d_fall,
   output logic [1:0]  m_rise,
   output logic [1:0]  m_fall,
   output logic        strobe
);
   initial begin
      cke = 1'b1;
      cmd = `CMD_NOP;
      bank_select = 2'h0;
      addr = 13'h0;
      d_rise = 16'h0;
      d_fall = 16'h0;
      m_rise = 2'h0;
      m_fall = 2'h0;
      strobe = 1'b0;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask : idle
   // one command for one rising edge, then NOP with inverted bank and address
   task automatic send(input logic [3:0] code, input logic [1:0] ba, input logic [12:0] a,
                       input logic cke_v = 1'b1);
      @(negedge clock);
      cmd = code;
      bank_select = ba;
      addr = a;
      cke = cke_v;
      @(negedge clock);
      cmd = `CMD_NOP;
      bank_select = ~ba;
      addr = ~a;
   endtask : send
   task automatic init_seq(input logic [12:0] base_op);
      idle(POWER_UP_IDLE);
      send(`CMD_PRECHARGE, 2'h0, 13'h0400);
      idle(PRECHARGE_WAIT);
      repeat (2) begin
         send(`CMD_REFRESH, 2'h0, 13'h0);
         idle(REFRESH_CYCLE_WAIT);
      end
      send(`CMD_MODE_LOAD, `MR_BASE_BANK, base_op);
      idle(MODE_LOAD_WAIT);
      send(`CMD_MODE_LOAD, `MR_EXT_BANK, 13'h0);
      idle(MODE_LOAD_WAIT);
   endtask : init_seq
   task automatic wr(input logic [1:0] ba, input logic [12:0] a, input int beats,
                     input logic [15:0] d [16], input logic [1:0] mr, input logic [1:0] mf);
      send(`CMD_WRITE, ba, a);
      for (int i = 0; i < beats; i++) begin
         d_rise = d[2 * i];
         d_fall = d[2 * i + 1];
         m_rise = (i == 0) ? mr : 2'h0;
         m_fall = (i == 0) ? mf : 2'h0;
         strobe = 1'b1;
         @(negedge clock);
      end
      strobe = 1'b0;
      d_rise = ~d_rise;
      d_fall = ~d_fall;
   endtask : wr
endmodule : lpddr_ctrl_model

/* File: lpddr_sdram_command_init_interface_bench.sv */
// self-checking bench for the lpddr core driven by the controller model
`timescale 1ns/1ps
`include "lpddr_map.svh"
module lpddr_sdram_command_init_interface_bench;
   localparam logic [12:0] ROW = 13'h1fff;
   logic        clk, srst, rd_ready, cke, strobe, oe, stb_lo, stb_hi, stb_oe;
   logic        init_done, cmd_error;
   logic [3:0]  cmd, bank_open;
   logic [1:0]  ba, m_rise, m_fall, power_state;
   logic [12:0] addr;
   logic [15:0] d_rise, d_fall, q_rise, q_fall;
   logic [15:0] wdata [16];
   logic [15:0] shadow [0:2047];
   int          n_mismatch, checks_done, bl, cl;
   bit          il;

   lpddr_ctrl_model u_lpddr_ctrl_model (.clock(clk), .cke(cke), .cmd(cmd),
      .bank_select(ba), .addr(addr), .d_rise(d_rise), .d_fall(d_fall),
      .m_rise(m_rise), .m_fall(m_fall), .strobe(strobe));
   lpddr_core u_lpddr_core (.CLOCK(clk), .SRST(srst), .CKE(cke), .CS_N(cmd[3]),
      .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]), .BANK_SELECT(ba), .ADDR(addr),
      .DATA_LINES_IN_RISE(d_rise), .DATA_LINES_IN_FALL(d_fall),
      .WRITE_BYTE_MASK_RISE(m_rise), .WRITE_BYTE_MASK_FALL(m_fall),
      .LOW_BYTE_STROBE_IN(strobe), .HIGH_BYTE_STROBE_IN(strobe),
      .DATA_LINES_OUT_RISE(q_rise), .DATA_LINES_OUT_FALL(q_fall), .DATA_LINES_OE(oe),
      .LOW_BYTE_STROBE_OUT(stb_lo), .HIGH_BYTE_STROBE_OUT(stb_hi), .STROBE_OE(stb_oe),
      .RD_READY(rd_ready), .INIT_DONE(init_done), .BANK_OPEN(bank_open),
      .POWER_STATE(power_state), .CMD_ERROR(cmd_error));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check_val
   task automatic check_cnt(input int got, input int exp, input string what);
      checks_done++;
      if (got != exp) begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : check_cnt
   task automatic wait_cyc(input int n);
      u_lpddr_ctrl_model.idle(n);
   endtask : wait_cyc
   // burst column order: wraps inside the block of the burst length
   function automatic int col_at(input int s, input int i);
      int blk;
      blk = s & ~(bl - 1);
      return il ? (blk | ((s ^ i) & (bl - 1))) : (blk | ((s + i) & (bl - 1)));
   endfunction : col_at
   // command, then count error pulses over the next three cycles
   task automatic send_chk(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a,
                           input logic cke_v, input int exp);
      int n;
      n = 0;
      u_lpddr_ctrl_model.send(code, b, a, cke_v);
      for (int k = 0; k < 3; k++) begin
         if (cmd_error === 1'b1) n++;
         wait_cyc(1);
      end
      check_cnt(n, exp, "error pulses");
   endtask : send_chk
   task automatic fill(input logic [15:0] base);
      for (int i = 0; i < 16; i++) wdata[i] = base + 16'(i * 257);
   endtask : fill
   task automatic write_burst(input int b, input int col, input logic [1:0] mr,
                              input logic [1:0] mf);
      int c;
      logic [1:0] m;
      for (int i = 0; i < bl; i++) begin
         c = b * 512 + col_at(col, i);
         m = (i == 0) ? mr : ((i == 1) ? mf : 2'h0);
         if (!m[0]) shadow[c][7:0] = wdata[i][7:0];
         if (!m[1]) shadow[c][15:8] = wdata[i][15:8];
      end
      u_lpddr_ctrl_model.wr(b[1:0], 13'(col), bl / 2, wdata, mr, mf);
      wait_cyc(2);
   endtask : write_burst
   task automatic read_burst(input int b, input int col, input logic ac, input int stall);
      int got, first;
      logic [12:0] a;
      a = 13'(col);
      a[`AUTO_CLOSE_BIT] = ac;
      got = 0;
      first = -1;
      u_lpddr_ctrl_model.send(`CMD_READ, b[1:0], a, 1'b1);
      for (int k = 0; k < 40 && got < bl / 2; k++) begin
         rd_ready = (k >= stall);
         if (oe === 1'b1 && rd_ready) begin
            if (first < 0) first = k;
            check_val(q_rise, shadow[b * 512 + col_at(col, 2 * got)], "rise beat");
            check_val(q_fall, shadow[b * 512 + col_at(col, 2 * got + 1)], "fall beat");
            check_val({stb_lo, stb_hi, stb_oe}, 16'h7, "read strobes");
            got++;
         end
         wait_cyc(1);
      end
      rd_ready = 1'b1;
      check_cnt(got, bl / 2, "beat pairs");
      if (got < bl / 2) print_verdict();
      if (stall == 0) check_cnt(first, cl, "read latency");
      check_val(oe, 16'h0, "bus released");
      wait_cyc(2);
   endtask : read_burst

   task automatic t_reset();
      check_val(init_done, 16'h0, "init after reset");
      check_val(bank_open, 16'h0, "banks after reset");
      check_val(power_state, 16'h0, "power after reset");
      check_val(oe, 16'h0, "bus after reset");
      send_chk(`CMD_READ, 2'h0, 13'h0, 1'b1, 1);
   endtask : t_reset
   task automatic t_init();
      u_lpddr_ctrl_model.init_seq(13'h0022);
      bl = 4;
      il = 0;
      cl = 2;
      wait_cyc(1);
      check_val(init_done, 16'h1, "init done");
   endtask : t_init
   task automatic t_commands();
      send_chk(4'hb, 2'h2, ROW, 1'b1, 0);
      check_val(bank_open, 16'h0, "deselected activate");
      send_chk(`CMD_ACTIVATE, 2'h2, ROW, 1'b1, 0);
      check_val(bank_open, 16'h4, "bank 2 open");
      send_chk(`CMD_ACTIVATE, 2'h2, ROW, 1'b1, 1);
      send_chk(`CMD_REFRESH, 2'h0, 13'h0, 1'b1, 1);
      send_chk(`CMD_WRITE, 2'h1, 13'h0, 1'b1, 1);
   endtask : t_commands
   task automatic t_data();
      fill(16'h1234);
      write_burst(2, 4, 2'h0, 2'h0);
      read_burst(2, 5, 1'b0, 0);
      fill(16'ha5c3);
      write_burst(2, 4, 2'h1, 2'h2);
      read_burst(2, 4, 1'b1, 0);
      check_val(bank_open, 16'h0, "auto close");
   endtask : t_data
   task automatic t_mode();
      send_chk(`CMD_MODE_LOAD, `MR_BASE_BANK, 13'h003b, 1'b1, 0);
      bl = 8;
      il = 1;
      cl = 3;
      send_chk(`CMD_ACTIVATE, 2'h1, ROW, 1'b1, 0);
      fill(16'h0f00);
      write_burst(1, 0, 2'h0, 2'h0);
      read_burst(1, 5, 1'b0, 0);
      read_burst(1, 2, 1'b0, 6);
      send_chk(`CMD_PRECHARGE, 2'h1, 13'h0, 1'b1, 0);
      check_val(bank_open, 16'h0, "bank 1 closed");
   endtask : t_mode
   task automatic t_lengths();
      int          lens [2] = '{2, 16};
      logic [12:0] ops [2] = '{13'h0021, 13'h0024};
      for (int j = 0; j < 2; j++) begin
         send_chk(`CMD_MODE_LOAD, `MR_BASE_BANK, ops[j], 1'b1, 0);
         bl = lens[j];
         il = 0;
         cl = 2;
         send_chk(`CMD_ACTIVATE, 2'h3, ROW, 1'b1, 0);
         fill(16'h3c00 + 16'(j));
         write_burst(3, 0, 2'h0, 2'h0);
         read_burst(3, bl - 1, 1'b1, 0);
      end
   endtask : t_lengths
   task automatic t_power();
      send_chk(`CMD_ACTIVATE, 2'h0, ROW, 1'b1, 0);
      send_chk(`CMD_NOP, 2'h0, 13'h0, 1'b0, 0);
      check_val(power_state, 16'h2, "active power-down");
      send_chk(`CMD_ACTIVATE, 2'h3, ROW, 1'b0, 0);
      send_chk(`CMD_NOP, 2'h0, 13'h0, 1'b1, 0);
      check_val(power_state, 16'h0, "awake");
      check_val(bank_open, 16'h1, "ignored while down");
      send_chk(`CMD_PRECHARGE, 2'h0, 13'h0, 1'b1, 0);
      send_chk(`CMD_REFRESH, 2'h0, 13'h0, 1'b1, 0);
      send_chk(`CMD_NOP, 2'h0, 13'h0, 1'b0, 0);
      check_val(power_state, 16'h1, "precharge power-down");
      send_chk(`CMD_NOP, 2'h0, 13'h0, 1'b1, 0);
      send_chk(`CMD_REFRESH, 2'h0, 13'h0, 1'b0, 0);
      check_val(power_state, 16'h3, "self refresh");
      send_chk(`CMD_NOP, 2'h0, 13'h0, 1'b1, 0);
      check_val(power_state, 16'h0, "self refresh exit");
   endtask : t_power

   initial begin
      srst = 1'b1;
      rd_ready = 1'b1;
      n_mismatch = 0;
      checks_done = 0;
      bl = 2;
      il = 0;
      cl = 3;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_init();
      t_commands();
      t_data();
      t_mode();
      t_lengths();
      t_power();
      print_verdict();
   end
endmodule : lpddr_sdram_command_init_interface_bench
